// file: src/conversion_step_scheduler.sv
// Cycle timer, rolling cycle counter, step triggers and power state control
`timescale 1ns/10ps
`default_nettype none
module conversion_step_scheduler #(
  // 100 ms in clock cycles; shorten for simulation
  parameter int unsigned BASE_PERIOD_CYC = conv_sched_pkg::BASE_PERIOD_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire logic                   cyclicEn,             // Cyclic execution enable
  input  wire logic [2:0]             cyclePeriodSel,       // Normal cycle period code
  input  wire logic [2:0]             sleepPeriodSel,       // Cyclic wakeup period code
  input  wire logic [5:0][2:0]        stepIntervalSel,      // Interval code of each optional step
  input  wire logic                   continuousMode,       // Cycles run back to back
  input  wire logic                   routineBusy,          // Conversion routine running
  input  wire logic                   routineDone,          // Pulse: routine finished
  input  wire logic                   sleepRequestCmd,      // Pulse: host sleep command
  input  wire logic                   wakeRequest,          // Pulse: host wake frame
  input  wire logic                   upstreamFaultLine,    // Pin, asynchronous
  input  wire logic                   internalFailure,      // Pulse: failure found in routine
  input  wire logic                   commTimeout,          // Pulse: host did not answer in time
  input  wire logic                   overrideClear,        // Pulse: host clears override latch
  input  wire logic                   slpBalConf,           // 1: silent balance, 0: sleep
  input  wire logic                   lpFilterWr,           // Pulse: write low-power filter code
  input  wire logic [2:0]             lpFilterCode,         // Requested low-power filter code
  output logic [1:0]                  pwrState,             // Current power state
  output logic [10:0]                 cycleCount,           // Rolling cycle counter
  output logic                        cycleStart,           // Pulse: a routine cycle begins
  output logic [5:0]                  stepTrigger,          // Pulses: run optional step
  output logic                        abortConversion,      // Pulse: drop running conversion
  output logic                        failsafeOverrideFlag, // Override latch
  output logic                        downstreamFaultLine,  // Fault toward the host
  output logic                        periodOverrunFault,   // Routine outlasted its period
  output logic [2:0]                  acqWindowLp           // Accepted low-power filter code
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // All state lives here; every output is one of these flip-flops
  conv_sched_pkg::pwr_state_t state_ff, nxt_state;     // Power state
  logic [31:0]                tmr_ff, nxt_tmr;         // Cycle timer
  logic [10:0]                cnt_ff, nxt_cnt;         // Cycle counter
  logic [5:0][2:0]            selQ_ff;                 // Shadow of interval codes
  logic [5:0]                 trig_ff;                 // Step trigger pulses
  logic                       start_ff;                // Cycle start pulse
  logic                       abort_ff;                // Abort pulse
  logic                       ovr_ff, nxt_ovr;         // Override latch
  logic                       fault_ff;                // Downstream fault line
  logic                       ovrPend_ff;              // Period overrun waiting for routine
  logic [2:0]                 lpFilt_ff;               // Low-power filter code
  logic                       upSync1_ff, upSync2_ff;  // Upstream fault synchroniser

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  // Counter bit watched for one interval code
  // Code to counter bit
  function automatic logic [3:0] bitOf(input logic [2:0] s);
    case (s)
      3'h1:    bitOf = conv_sched_pkg::BIT_SEL1;
      3'h2:    bitOf = conv_sched_pkg::BIT_SEL2;
      3'h3:    bitOf = conv_sched_pkg::BIT_SEL3;
      3'h4:    bitOf = conv_sched_pkg::BIT_SEL4;
      3'h5:    bitOf = conv_sched_pkg::BIT_SEL5;
      3'h6:    bitOf = conv_sched_pkg::BIT_SEL6;
      3'h7:    bitOf = conv_sched_pkg::BIT_SEL7;
      default: bitOf = conv_sched_pkg::BIT_SEL1;
    endcase
  endfunction

  wire inNormal  = (state_ff == conv_sched_pkg::ST_NORMAL);
  wire inCyclic  = (state_ff == conv_sched_pkg::ST_CYCLIC_WAKE);
  // Timer only runs while cyclic activity is live
  wire running   = (inNormal && cyclicEn) || inCyclic;
  wire [2:0] periodSel = inCyclic ? sleepPeriodSel : cyclePeriodSel;
  wire [31:0] periodCyc = 32'(BASE_PERIOD_CYC) << periodSel;
  // Expiry at period minus one makes each period exactly N cycles
  wire tmrDone   = (tmr_ff >= periodCyc - 32'h1);
  // Continuous or overrun paces cycles by routine end
  wire byRoutine = continuousMode || ovrPend_ff;
  // A busy routine at expiry defers the boundary rather than cutting it
  wire cycAdv    = running && (byRoutine ? routineDone : (tmrDone && !routineBusy));
  wire setOvrPend = running && !continuousMode && tmrDone && routineBusy;
  // Natural 11-bit wrap from 2047 to zero
  assign nxt_cnt = cycAdv ? cnt_ff + 11'h001 : cnt_ff;
  // Bits flipped by this increment; the wrap to zero flips them all
  wire [10:0] toggled = cnt_ff ^ (cnt_ff + 11'h001);

  // Fire on toggle of the selected bit
  logic [5:0] trigNow;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_step
      assign trigNow[gi] = cycAdv && (selQ_ff[gi] != conv_sched_pkg::SEL_EXCLUDED)
                           && toggled[bitOf(selQ_ff[gi])];
    end
  endgenerate

  // Timer restarts at each cycle and holds once expired
  assign nxt_tmr = (!running || cycAdv) ? 32'h0 : (tmrDone ? tmr_ff : tmr_ff + 32'h1);

  // Host wake or upstream fault high, after synchronising
  wire wakeEvt = wakeRequest || upSync2_ff;

  // Latch set wins over host clear
  assign nxt_ovr = internalFailure || (ovr_ff && !overrideClear);

  // Low-power target chosen from the cyclic enable
  conv_sched_pkg::pwr_state_t lpTarget;
  // Cyclic wakeup, otherwise sleep or silent balance
  assign lpTarget = cyclicEn ? conv_sched_pkg::ST_CYCLIC_WAKE :
                    (slpBalConf ? conv_sched_pkg::ST_SILENT_BAL : conv_sched_pkg::ST_SLEEP);
  // Sleep request honoured only with no override
  wire goLowPower = inNormal && sleepRequestCmd && !ovr_ff;
  wire forceSleep = inNormal && ovr_ff && commTimeout;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      conv_sched_pkg::ST_NORMAL: begin
        // Override keeps the device in normal unless a host timeout forces sleep
        if (forceSleep) begin
          nxt_state = conv_sched_pkg::ST_SLEEP;
        end else if (goLowPower) begin
          nxt_state = lpTarget;
        end
      end
      conv_sched_pkg::ST_CYCLIC_WAKE: begin
        // Any wake, failure included, returns to normal
        if (internalFailure || wakeEvt) begin
          nxt_state = conv_sched_pkg::ST_NORMAL;
        end
      end
      conv_sched_pkg::ST_SLEEP, conv_sched_pkg::ST_SILENT_BAL: begin
        // Plain low-power states leave on any wake
        if (wakeEvt) begin
          nxt_state = conv_sched_pkg::ST_NORMAL;
        end
      end
      default: nxt_state = conv_sched_pkg::ST_NORMAL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upstream fault synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      upSync1_ff <= 1'b0;
      upSync2_ff <= 1'b0;
    end else begin
      upSync1_ff <= upstreamFaultLine;
      upSync2_ff <= upSync1_ff;
    end
  end

  // Cycle timer and counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tmr_ff     <= 32'h0;
      cnt_ff     <= conv_sched_pkg::RST_COUNT;
      ovrPend_ff <= 1'b0;
      start_ff   <= 1'b0;
      trig_ff    <= 6'h00;
    end else begin
      tmr_ff     <= nxt_tmr;
      cnt_ff     <= nxt_cnt;
      // Overrun waits for the routine to end
      ovrPend_ff <= (cycAdv || !running) ? 1'b0 : (ovrPend_ff || setOvrPend);
      start_ff   <= cycAdv;
      trig_ff    <= trigNow;
    end
  end

  // Interval shadow: a mid-cycle change would skew the toggle pattern
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      selQ_ff <= '0;
    end else if (cycAdv || !running) begin
      // Load at a cycle boundary or while the timer is stopped
      selQ_ff <= stepIntervalSel;
    end
  end

  // Power state, override and filter code
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff  <= conv_sched_pkg::ST_NORMAL;
      ovr_ff    <= 1'b0;
      fault_ff  <= 1'b0;
      abort_ff  <= 1'b0;
      lpFilt_ff <= conv_sched_pkg::RST_LP_FILTER;
    end else begin
      state_ff <= nxt_state;
      ovr_ff   <= nxt_ovr;
      // Fault line follows the override latch
      fault_ff <= nxt_ovr;
      abort_ff <= goLowPower;
      // Limitation: a refused code is dropped with no status to show it
      // Codes from four upward are refused
      if (lpFilterWr && (lpFilterCode < conv_sched_pkg::LP_FILTER_CODES)) begin
        lpFilt_ff <= lpFilterCode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Plain renames; nothing combinational reaches a pin
  assign pwrState             = state_ff;
  assign cycleCount           = cnt_ff;
  assign cycleStart           = start_ff;
  assign stepTrigger          = trig_ff;
  assign abortConversion      = abort_ff;
  assign failsafeOverrideFlag = ovr_ff;
  assign downstreamFaultLine  = fault_ff;
  assign periodOverrunFault   = ovrPend_ff;
  assign acqWindowLp          = lpFilt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Internal terms are watched where they state intent more plainly than pins
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence sleepAccepted;
    inNormal && sleepRequestCmd && !ovr_ff && !commTimeout && cyclicEn;
  endsequence
  sequence inCyclicWake;
    pwrState == conv_sched_pkg::ST_CYCLIC_WAKE && abortConversion;
  endsequence

  cnt_wrap_a: assert property (cycAdv && cnt_ff == conv_sched_pkg::CNT_MAX |=> cycleCount == 11'h000)
    else $error("cycle counter did not wrap to zero");
  cnt_step_a: assert property (cycAdv |=> cycleCount == $past(cnt_ff) + 11'h001 && cycleStart)
    else $error("cycle counter did not advance");
  every_cycle_a: assert property (cycAdv && selQ_ff[0] == 3'h1 |=> stepTrigger[0])
    else $error("code one step did not fire");
  // Watched on the step that the bench really excludes
  excluded_step_a: assert property (cycAdv && selQ_ff[0] == conv_sched_pkg::SEL_EXCLUDED
                                    |=> !stepTrigger[0])
    else $error("excluded step fired");
  override_hold_a: assert property (inNormal && ovr_ff && !commTimeout
                                    |=> pwrState == conv_sched_pkg::ST_NORMAL)
    else $error("left normal with override latched");
  timeout_sleep_a: assert property (inNormal && ovr_ff && commTimeout
                                    |=> pwrState == conv_sched_pkg::ST_SLEEP)
    else $error("timeout did not force sleep");
  cyclic_entry_a: assert property (sleepAccepted |=> inCyclicWake)
    else $error("sleep request did not enter cyclic wakeup");
  fault_raise_a: assert property (internalFailure |=> downstreamFaultLine && failsafeOverrideFlag)
    else $error("failure did not raise fault line");
  failure_wake_a: assert property (inCyclic && internalFailure |=> inNormal && ovr_ff)
    else $error("failure in wakeup did not return to normal");
  filter_refuse_a: assert property (lpFilterWr && lpFilterCode >= 3'h4 |=> $stable(acqWindowLp))
    else $error("illegal low-power filter accepted");
  sleep_pick_a: assert property (inNormal && sleepRequestCmd && !ovr_ff && !cyclicEn && slpBalConf
                                 |=> pwrState == conv_sched_pkg::ST_SILENT_BAL)
    else $error("silent balance not entered");
  // While running, a boundary is the only place a new interval code may land
  interval_hold_a: assert property (running && !cycAdv |=> $stable(selQ_ff))
    else $error("interval code changed mid-cycle");
  // Outside continuous mode, a busy routine at expiry raises the overrun flag
  overrun_set_a: assert property (setOvrPend && !ovrPend_ff |=> periodOverrunFault)
    else $error("period overrun not flagged");
  // A legal filter code is stored as written
  filter_take_a: assert property (lpFilterWr && lpFilterCode < 3'h4
                                  |=> acqWindowLp == $past(lpFilterCode))
    else $error("legal low-power filter not stored");
  // Host clear drops latch and fault line together
  latch_clear_a: assert property (overrideClear && !internalFailure
                                  |=> !failsafeOverrideFlag && !downstreamFaultLine)
    else $error("override clear did not drop fault line");
  // A refused sleep request must not abort the routine
  refused_abort_a: assert property (inNormal && ovr_ff && sleepRequestCmd |=> !abortConversion)
    else $error("refused sleep request aborted conversion");
  // A plain wake leaves cyclic wakeup for normal
  cyclic_wake_a: assert property (inCyclic && wakeEvt |=> pwrState == conv_sched_pkg::ST_NORMAL)
    else $error("wake did not return to normal");

endmodule
`default_nettype wire

// file: common/conv_sched_pkg.sv
// Constants and types for the conversion step scheduler
package conv_sched_pkg;
  // Clock rate and the base cycle period
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned BASE_PERIOD_MS = 100;
  // Cycles per 100 ms; each period code doubles it
  localparam int unsigned BASE_PERIOD_CYC = CLK_FREQ_HZ / 1000 * BASE_PERIOD_MS;
  // Field widths and counts
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned CNT_W     = 11;
  localparam int unsigned NSTEP     = 6;
  localparam int unsigned TMR_W     = 32;
  localparam int unsigned FILT_W    = 3;
  // Only filter codes below this value are legal for low power
  localparam logic [2:0]  LP_FILTER_CODES = 3'h4;
  // Interval code that excludes a step
  localparam logic [2:0]  SEL_EXCLUDED    = 3'h0;
  // Values after reset, and the counter's top value
  localparam logic [10:0] RST_COUNT       = 11'h000;
  localparam logic [10:0] CNT_MAX         = 11'h7ff;
  localparam logic [2:0]  RST_LP_FILTER   = 3'h0;
  // Counter bit watched for each interval code
  localparam logic [3:0]  BIT_SEL1 = 4'h0;
  localparam logic [3:0]  BIT_SEL2 = 4'h2;
  localparam logic [3:0]  BIT_SEL3 = 4'h4;
  localparam logic [3:0]  BIT_SEL4 = 4'h6;
  localparam logic [3:0]  BIT_SEL5 = 4'h7;
  localparam logic [3:0]  BIT_SEL6 = 4'h9;
  localparam logic [3:0]  BIT_SEL7 = 4'ha;
  // Operating states of the device
  typedef enum logic [1:0] {
    ST_NORMAL      = 2'b00,
    ST_SLEEP       = 2'b01,
    ST_CYCLIC_WAKE = 2'b10,
    ST_SILENT_BAL  = 2'b11
  } pwr_state_t;
endpackage

// file: bench/host_model.sv
// Host controller model that sends state commands to the scheduler
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [2:0] cmdCode,              // 1 sleep 2 wake 3 clear 4 timeout 5 clear then sleep
  input  wire logic       cmdGo,                // Pulse: issue cmdCode
  input  wire logic       failsafeOverrideFlag, // Override latch as the host reads it
  output logic            sleepRequestCmd,
  output logic            wakeRequest,
  output logic            overrideClear,
  output logic            commTimeout
);
  logic [3:0] pulse_ff; // One-cycle command pulses
  logic [1:0] wait_ff;  // Countdown to a deferred sleep command
  assign {commTimeout, overrideClear, wakeRequest, sleepRequestCmd} = pulse_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Each frame becomes one pulse; code 5 is the careful host sequence
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pulse_ff <= 4'h0;
      wait_ff  <= 2'h0;
    end else begin
      pulse_ff <= 4'h0;
      // Plain command, sent even when the latch is set
      if (cmdGo && cmdCode != 3'h5) begin
        pulse_ff <= 4'h1 << (cmdCode - 3'h1);
      end
      if (cmdGo && cmdCode == 3'h5) begin
        pulse_ff[2] <= failsafeOverrideFlag;
        wait_ff     <= 2'h3;
      end
      if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end
      if (wait_ff == 2'h1 && !failsafeOverrideFlag) begin
        pulse_ff[0] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_conversion_step_scheduler.sv
// Self-checking bench for the conversion step scheduler
`timescale 1ns/10ps
`default_nettype none
module tb_conversion_step_scheduler;
  localparam int BASE = 8; // Short base period keeps the run brief
  logic            sys_clk = 1'b0, srst = 1'b1, cyclicEn = 1'b0, continuousMode = 1'b0;
  logic            routineBusy = 1'b0, slpBalConf = 1'b0, upstreamFaultLine = 1'b0, cmdGo = 1'b0;
  logic [2:0]      cyclePeriodSel = 3'h0, sleepPeriodSel = 3'h0, lpFilterCode = 3'h0;
  logic [2:0]      pul = 3'h0, cmdCode = 3'h0; // Pulses: done, failure, filter write
  logic [5:0][2:0] stepIntervalSel = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
  logic [1:0]      pwrState;
  logic [10:0]     cycleCount;
  logic [5:0]      stepTrigger;
  logic [2:0]      acqWindowLp;
  logic            cycleStart, abortConversion, failsafeOverrideFlag, downstreamFaultLine;
  logic            periodOverrunFault, sleepRequestCmd, wakeRequest, overrideClear, commTimeout;
  int              err_total = 0, n_checks = 0, nStart = 0, nAbort = 0, s, a, t0;
  int              nTrig[6] = '{default: 0};
  int              bitOf[6] = '{0, 2, 4, 6, 7, 9}; // Watched counter bit per step
  longint          tStart = 0, gap = 0;             // Cycles between the last two starts
  always #5 sys_clk = ~sys_clk;
  conversion_step_scheduler #(.BASE_PERIOD_CYC(BASE)) conversion_step_scheduler_inst (
    .sys_clk(sys_clk), .srst(srst), .cyclicEn(cyclicEn), .cyclePeriodSel(cyclePeriodSel),
    .sleepPeriodSel(sleepPeriodSel), .stepIntervalSel(stepIntervalSel), .continuousMode(continuousMode),
    .routineBusy(routineBusy), .routineDone(pul[0]), .sleepRequestCmd(sleepRequestCmd),
    .wakeRequest(wakeRequest), .upstreamFaultLine(upstreamFaultLine), .internalFailure(pul[1]),
    .commTimeout(commTimeout), .overrideClear(overrideClear), .slpBalConf(slpBalConf),
    .lpFilterWr(pul[2]), .lpFilterCode(lpFilterCode), .pwrState(pwrState), .cycleCount(cycleCount),
    .cycleStart(cycleStart), .stepTrigger(stepTrigger), .abortConversion(abortConversion),
    .failsafeOverrideFlag(failsafeOverrideFlag), .downstreamFaultLine(downstreamFaultLine),
    .periodOverrunFault(periodOverrunFault), .acqWindowLp(acqWindowLp));
  host_model host_model_inst (
    .sys_clk(sys_clk), .srst(srst), .cmdCode(cmdCode), .cmdGo(cmdGo),
    .failsafeOverrideFlag(failsafeOverrideFlag), .sleepRequestCmd(sleepRequestCmd),
    .wakeRequest(wakeRequest), .overrideClear(overrideClear), .commTimeout(commTimeout));
  ////////////////////////////////////////////////////////////////////////////
  // Tally output pulses; counts are read at falling edges
  always @(posedge sys_clk) begin
    if (cycleStart === 1'b1) begin
      nStart <= nStart + 1;
      gap    <= ($time - tStart) / 10;
      tStart <= $time;
    end
    if (abortConversion === 1'b1) nAbort <= nAbort + 1;
    for (int i = 0; i < 6; i++) if (stepTrigger[i] === 1'b1) nTrig[i] <= nTrig[i] + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tk();
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Stimulus tasks are entered at a rising edge
  task automatic pulse(input int i);
    pul[i] <= 1'b1;
    @(posedge sys_clk);
    pul <= 3'h0;
  endtask
  task automatic hcmd(input logic [2:0] c);
    cmdCode <= c;
    cmdGo   <= 1'b1;
    @(posedge sys_clk);
    cmdGo   <= 1'b0;
  endtask
  function automatic logic [1:0] probe(input int w);
    return (w == 0) ? pwrState : {1'b0, periodOverrunFault};
  endfunction
  // Bounded waits; running out ends the run
  task automatic waitfor(input int w, input logic [1:0] exp);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge sys_clk);
      if (probe(w) === exp) break;
    end
    chk(probe(w), exp);
    if (k == 40) give_verdict();
  endtask
  task automatic waitstarts(input int n, input int bound);
    for (int k = 0; k < bound && nStart < n; k++) @(negedge sys_clk);
    chk(nStart >= n, 1);
    if (nStart < n) give_verdict();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    idle(1);
    chk({pwrState, cycleCount, failsafeOverrideFlag, downstreamFaultLine}, 0);
    tk();
    cyclEnSet: cyclicEn <= 1'b1;
    waitstarts(1024, 8300);
    // Step 5 moves to code 7 from the next boundary on
    tk();
    stepIntervalSel[5] <= 3'h7;
    waitstarts(2048, 8300);
    chk(cycleCount, 11'h000);
    chk(32'(gap), BASE);
    for (int i = 0; i < 5; i++) chk(nTrig[i], 2048 >> bitOf[i]);
    chk(nTrig[5], (1024 >> 9) + (1024 >> 10));
    tk();
    cyclePeriodSel <= 3'h2;
    stepIntervalSel[0] <= conv_sched_pkg::SEL_EXCLUDED;
    t0 = nTrig[0];
    s = nStart;
    waitstarts(s + 3, 120);
    chk(nTrig[0], t0 + 1);
    chk(32'(gap), BASE << 2);
    tk();
    routineBusy <= 1'b1;
    waitfor(1, 2'h1);
    s = nStart;
    idle(10);
    chk(nStart, s);
    tk();
    routineBusy <= 1'b0;
    pulse(0);
    waitstarts(s + 1, 6);
    tk();
    continuousMode <= 1'b1;
    s = nStart;
    idle(80);
    chk(nStart, s);
    tk();
    pulse(0);
    waitstarts(s + 1, 6);
    tk();
    continuousMode <= 1'b0;
    sleepPeriodSel <= 3'h3;
    a = nAbort;
    hcmd(3'h1);
    waitfor(0, conv_sched_pkg::ST_CYCLIC_WAKE);
    // The abort pulse is tallied one edge after the state moves
    idle(1);
    chk(nAbort, a + 1);
    waitstarts(nStart + 3, 230);
    chk(32'(gap), BASE << 3);
    for (int i = 0; i < 2; i++) begin
      tk();
      lpFilterCode <= (i == 0) ? 3'h3 : conv_sched_pkg::LP_FILTER_CODES;
      pulse(2);
      idle(2);
      chk(acqWindowLp, 3'h3);
    end
    tk();
    hcmd(3'h2);
    waitfor(0, conv_sched_pkg::ST_NORMAL);
    tk();
    hcmd(3'h1);
    waitfor(0, conv_sched_pkg::ST_CYCLIC_WAKE);
    tk();
    pulse(1);
    waitfor(0, conv_sched_pkg::ST_NORMAL);
    chk({failsafeOverrideFlag, downstreamFaultLine}, 2'h3);
    a = nAbort;
    tk();
    hcmd(3'h1);
    idle(6);
    chk(pwrState, conv_sched_pkg::ST_NORMAL);
    chk(nAbort, a);
    tk();
    hcmd(3'h4);
    waitfor(0, conv_sched_pkg::ST_SLEEP);
    tk();
    upstreamFaultLine <= 1'b1;
    waitfor(0, conv_sched_pkg::ST_NORMAL);
    tk();
    upstreamFaultLine <= 1'b0;
    idle(4);
    tk();
    cyclicEn <= 1'b0;
    slpBalConf <= 1'b1;
    hcmd(3'h5);
    waitfor(0, conv_sched_pkg::ST_SILENT_BAL);
    chk(failsafeOverrideFlag, 1'b0);
    tk();
    hcmd(3'h2);
    waitfor(0, conv_sched_pkg::ST_NORMAL);
    tk();
    slpBalConf <= 1'b0;
    hcmd(3'h1);
    waitfor(0, conv_sched_pkg::ST_SLEEP);
    give_verdict();
  end
endmodule
`default_nettype wire
